// file: bench/mid_line_model.sv
// Partner model: remote FSK sender plus the bit-rate divider strobe.
// Assumes its tasks are called at a falling edge of mclk_in.
module mid_line_model (
    input wire logic mclk_in,
    output logic bit_tick_out,
    output logic rx_bit_out,
    output logic carrier_out
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        bit_tick_out = 1'b0;
        rx_bit_out = 1'b1;
        carrier_out = 1'b0;
    end

    // One bit time is five clocks, with the mid-bit strobe in the third.
    // A dropped carrier leaves the line wandering, so the level toggles each clock.
    task automatic bit_time(input logic b, input logic car);
        integer i;
        for (i = 0; i < 5; i++) begin
            if (car) begin
                rx_bit_out = b;
            end else begin
                rx_bit_out = ~rx_bit_out;
            end
            carrier_out = car;
            bit_tick_out = (i == 2);
            @(negedge mclk_in);
        end
    endtask

    task automatic send_bit(input logic b);
        bit_time(b, 1'b1);
    endtask

    task automatic send_char(input logic [7:0] d, input logic par, input logic stop, input logic with_par);
        integer i;
        send_bit(1'b0);
        for (i = 0; i < 8; i++) begin
            send_bit(d[i]);
        end
        if (with_par) begin
            send_bit(par);
        end
        send_bit(stop);
    endtask

    task automatic drop(input integer n);
        repeat (n) bit_time(1'b0, 1'b0);
    endtask
endmodule // mid_line_model

// file: bench/tb_top.sv
// Self-checking bench for the message interval detector.
// Assumes the partner model drives the line side and strobe.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic mclk_in;
    logic sys_rst_in;
    logic [2:0] mode_sw;
    logic bit_tick;
    logic rx_bit;
    logic carrier;
    logic rxd;
    logic msg_gap;
    logic char_valid;
    logic mode_ready;
    mid_pkg::mid_char_t char_q;
    mid_pkg::mid_char_t last_char;
    mid_pkg::mid_mode_t mode_q;
    integer err_count;
    integer checked;
    integer n_valid = 0;
    integer m;
    integer th;

    mid_detector dut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .mode_sw_in(mode_sw), .bit_tick_in(bit_tick),
        .rx_bit_in(rx_bit), .carrier_in(carrier), .rxd_out(rxd), .msg_gap_out(msg_gap),
        .char_valid_out(char_valid), .char_out(char_q), .mode_out(mode_q), .mode_ready_out(mode_ready));

    mid_line_model lm (.mclk_in(mclk_in), .bit_tick_out(bit_tick), .rx_bit_out(rx_bit), .carrier_out(carrier));

    initial begin
        mclk_in = 1'b0;
        forever #20 mclk_in = ~mclk_in;
    end

    always @(posedge mclk_in) begin
        if (char_valid === 1'b1) begin
            last_char <= char_q;
            n_valid <= n_valid + 1;
        end
    end

    // ------------------------------------------------------------------
    // Compare and access tasks.
    // ------------------------------------------------------------------
    task automatic chk_bit(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_vec(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_char(input integer n, input logic [7:0] d, input logic p, input logic f);
        chk_vec(16'(n_valid), 16'(n));
        chk_vec(16'(last_char), {6'h00, d, p, f});
    endtask

    // Power cycle with the given switches, then move the switches away.
    task automatic power_up(input logic [2:0] sw);
        @(negedge mclk_in);
        sys_rst_in = 1'b1;
        mode_sw = sw;
        repeat (4) @(negedge mclk_in);
        chk_bit(mode_ready, 1'b0);
        chk_bit(rxd, 1'b1);
        sys_rst_in = 1'b0;
        repeat (2) @(negedge mclk_in);
        chk_vec(16'(mode_q), 16'(sw));
        chk_bit(mode_ready, 1'b1);
        mode_sw = ~sw;
        repeat (2) @(negedge mclk_in);
        chk_vec(16'(mode_q), 16'(sw));
    endtask

    task final_report;
        $display("Comparisons: %0d, mismatches: %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #400000;
        err_count++;
        $display("Watchdog expired at %0t", $time);
        final_report;
    end

    // ------------------------------------------------------------------
    // Test sequence.
    // ------------------------------------------------------------------
    initial begin
        err_count = 0;
        checked = 0;
        sys_rst_in = 1'b1;
        mode_sw = 3'h0;
        power_up(3'h0);
        chk_vec(16'(mode_q), 16'(mid_pkg::MID_ASYNC11));
        lm.send_bit(1'b1);
        lm.send_char(8'hA5, 1'b1, 1'b1, 1'b1);
        chk_char(1, 8'hA5, 1'b1, 1'b0);
        lm.send_char(8'h3C, 1'b0, 1'b0, 1'b1);
        chk_char(2, 8'h3C, 1'b0, 1'b1);
        repeat (2) lm.send_bit(1'b1);
        chk_bit(msg_gap, 1'b0);
        power_up(3'h1);
        lm.send_bit(1'b1);
        lm.send_char(8'h5A, 1'b0, 1'b1, 1'b0);
        chk_char(3, 8'h5A, 1'b0, 1'b0);
        lm.send_char(8'hC3, 1'b0, 1'b1, 1'b0);
        chk_char(4, 8'hC3, 1'b0, 1'b0);
        for (m = 2; m < 4; m++) begin
            power_up(m[2:0]);
            lm.send_bit(~m[0]);
            chk_bit(rxd, ~m[0]);
            lm.send_bit(m[0]);
            chk_bit(rxd, m[0]);
            lm.drop(30);
            chk_bit(msg_gap, 1'b0);
            repeat (4) begin
                lm.drop(1);
                chk_bit(rxd, m[0]);
            end
        end
        for (m = 4; m < 8; m++) begin
            th = m[1] ? 24 : 12;
            power_up(m[2:0]);
            lm.send_bit(~m[0]);
            repeat (th - 1) lm.send_bit(m[0]);
            chk_bit(msg_gap, 1'b0);
            lm.send_bit(~m[0]);
            repeat (th - 1) lm.send_bit(m[0]);
            chk_bit(msg_gap, 1'b0);
            lm.send_bit(m[0]);
            chk_bit(msg_gap, 1'b1);
            lm.send_bit(m[0]);
            chk_bit(msg_gap, 1'b1);
            lm.send_bit(~m[0]);
            chk_bit(msg_gap, 1'b0);
        end
        final_report;
    end
endmodule // tb_top

// file: pkg/mid_pkg.sv
// Package for the message interval detector: modes, framer states, the
// received-character record and every count the block uses.
// Assumes one system clock and a bit-time strobe from the bit-rate divider.
package mid_pkg;

    // ------------------------------------------------------------------
    // Recognition modes, as coded on the three mode switches.
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        MID_ASYNC11     = 3'b000,
        MID_ASYNC10     = 3'b001,
        MID_OFF_IDLE0   = 3'b010,
        MID_OFF_IDLE1   = 3'b011,
        MID_SHORT_IDLE0 = 3'b100,
        MID_SHORT_IDLE1 = 3'b101,
        MID_LONG_IDLE0  = 3'b110,
        MID_LONG_IDLE1  = 3'b111
    } mid_mode_t;

    // ------------------------------------------------------------------
    // Character framer states.
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        MID_ST_IDLE   = 2'b00,
        MID_ST_DATA   = 2'b01,
        MID_ST_PARITY = 2'b10,
        MID_ST_STOP   = 2'b11
    } mid_state_t;

    // ------------------------------------------------------------------
    // Counts and widths.
    // ------------------------------------------------------------------
    localparam int MID_DATA_BITS = 8;
    localparam int MID_CNT_W = 5;
    localparam int MID_BIT_IDX_W = 3;
    localparam logic [MID_CNT_W-1:0] MID_SHORT_GAP_BITS = 5'h0C;
    localparam logic [MID_CNT_W-1:0] MID_LONG_GAP_BITS = 5'h18;
    localparam logic [MID_CNT_W-1:0] MID_CNT_MAX = 5'h1F;
    localparam logic [MID_BIT_IDX_W-1:0] MID_LAST_BIT_IDX = 3'h7;
    localparam logic [MID_CNT_W-1:0] MID_FRAME11_TICKS = 5'h0A;
    localparam logic [MID_CNT_W-1:0] MID_FRAME10_TICKS = 5'h09;
    localparam logic MID_MARK_LEVEL = 1'b1;

    // ------------------------------------------------------------------
    // One received character.
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [MID_DATA_BITS-1:0] data;
        logic parity;
        logic framing_err;
    } mid_char_t;

endpackage

// file: verilog/mid_detector.sv
// Receive-side character recognition and message-interval detector.
// Assumes rx_bit_in and carrier_in are synchronous demodulator outputs and
// bit_tick_in strobes once per bit time at the middle of each bit.
//
// Operation
// - Mode comes from switches five to seven.
// - Mode sampled at power-up only, then held.
// - 11-bit: start, eight data, parity, stop.
// - 10-bit: start, eight data, stop, no parity.
// - Interval off: pass any stream, no gaps.
// - Interval off, idle 0: output 0 without carrier.
// - Interval off, idle 1: output 1 without carrier.
// - Short, idle 0: gap after twelve zero bits.
// - Short, idle 1: gap after twelve one bits.
// - Long, idle 0: gap after twenty-four zero bits.
// - Long, idle 1: gap after twenty-four one bits.
module mid_detector (
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire logic [2:0] mode_sw_in,
    input wire logic bit_tick_in,
    input wire logic rx_bit_in,
    input wire logic carrier_in,
    output logic rxd_out,
    output logic msg_gap_out,
    output logic char_valid_out,
    output mid_pkg::mid_char_t char_out,
    output mid_pkg::mid_mode_t mode_out,
    output logic mode_ready_out
);

    // ------------------------------------------------------------------
    // Mode capture.
    // ------------------------------------------------------------------
    mid_pkg::mid_mode_t mode_reg;
    mid_pkg::mid_mode_t mode_next;
    logic captured_reg;
    mid_pkg::mid_mode_t sw_mode;

    // Every three-bit code is a defined mode; anything else falls to 11-bit.
    always_comb begin
        case (mode_sw_in)
            3'h1: sw_mode = mid_pkg::MID_ASYNC10;
            3'h2: sw_mode = mid_pkg::MID_OFF_IDLE0;
            3'h3: sw_mode = mid_pkg::MID_OFF_IDLE1;
            3'h4: sw_mode = mid_pkg::MID_SHORT_IDLE0;
            3'h5: sw_mode = mid_pkg::MID_SHORT_IDLE1;
            3'h6: sw_mode = mid_pkg::MID_LONG_IDLE0;
            3'h7: sw_mode = mid_pkg::MID_LONG_IDLE1;
            default: sw_mode = mid_pkg::MID_ASYNC11;
        endcase
    end

    // Switches are read once, on the first edge after power-up reset.
    assign mode_next = captured_reg ? mode_reg : sw_mode;

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            mode_reg <= mid_pkg::MID_ASYNC11;
            captured_reg <= 1'b0;
        end else begin
            mode_reg <= mode_next;
            captured_reg <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Mode decode.
    // ------------------------------------------------------------------
    wire logic is_async11 = (mode_reg == mid_pkg::MID_ASYNC11);
    wire logic is_async10 = (mode_reg == mid_pkg::MID_ASYNC10);
    wire logic is_async = captured_reg && (is_async11 || is_async10);
    wire logic is_mid_off = (mode_reg == mid_pkg::MID_OFF_IDLE0) || (mode_reg == mid_pkg::MID_OFF_IDLE1);
    wire logic is_mid_on = captured_reg && mode_reg[2];
    wire logic idle_level = mode_reg[0];
    wire logic [mid_pkg::MID_CNT_W-1:0] gap_threshold =
        mode_reg[1] ? mid_pkg::MID_LONG_GAP_BITS : mid_pkg::MID_SHORT_GAP_BITS;

    // ------------------------------------------------------------------
    // Line data to the terminal.
    // ------------------------------------------------------------------
    logic rxd_reg;
    logic rxd_next;

    // Without carrier the terminal sees the idle level in the off and interval modes, mark in both async modes.
    assign rxd_next = carrier_in ? rx_bit_in :
                      (is_mid_off || mode_reg[2]) ? idle_level : mid_pkg::MID_MARK_LEVEL;

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            rxd_reg <= mid_pkg::MID_MARK_LEVEL;
        end else begin
            rxd_reg <= rxd_next;
        end
    end

    // ------------------------------------------------------------------
    // Message interval detection.
    // ------------------------------------------------------------------
    logic gap_raw;
    logic gap_reg;

    mid_gap_counter u_gap (
        .mclk_in(mclk_in),
        .sys_rst_in(sys_rst_in),
        .enable_in(is_mid_on),
        .bit_tick_in(bit_tick_in),
        .rx_bit_in(rx_bit_in),
        .idle_level_in(idle_level),
        .threshold_in(gap_threshold),
        .gap_out(gap_raw)
    );

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            gap_reg <= 1'b0;
        end else begin
            gap_reg <= gap_raw && is_mid_on;
        end
    end

    // ------------------------------------------------------------------
    // Asynchronous character framer.
    // ------------------------------------------------------------------
    mid_pkg::mid_state_t state_reg;
    mid_pkg::mid_state_t state_next;
    logic [mid_pkg::MID_BIT_IDX_W-1:0] bit_idx_reg;
    logic [mid_pkg::MID_DATA_BITS-1:0] shift_reg;
    logic parity_reg;
    logic valid_reg;
    mid_pkg::mid_char_t char_reg;
    wire logic last_data = (bit_idx_reg == mid_pkg::MID_LAST_BIT_IDX);
    wire logic stop_tick = bit_tick_in && (state_reg == mid_pkg::MID_ST_STOP);

    always_comb begin
        state_next = state_reg;
        if (!is_async) begin
            state_next = mid_pkg::MID_ST_IDLE;
        end else if (bit_tick_in) begin
            case (state_reg)
                mid_pkg::MID_ST_IDLE: begin
                    if (!rx_bit_in) begin
                        state_next = mid_pkg::MID_ST_DATA;
                    end
                end
                mid_pkg::MID_ST_DATA: begin
                    if (last_data) begin
                        state_next = is_async11 ? mid_pkg::MID_ST_PARITY : mid_pkg::MID_ST_STOP;
                    end
                end
                mid_pkg::MID_ST_PARITY: state_next = mid_pkg::MID_ST_STOP;
                default: state_next = mid_pkg::MID_ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            state_reg <= mid_pkg::MID_ST_IDLE;
            bit_idx_reg <= '0;
            shift_reg <= '0;
            parity_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            if (bit_tick_in && state_reg == mid_pkg::MID_ST_DATA) begin
                shift_reg <= {rx_bit_in, shift_reg[mid_pkg::MID_DATA_BITS-1:1]};
                bit_idx_reg <= bit_idx_reg + 1'b1;
            end else if (state_reg == mid_pkg::MID_ST_IDLE) begin
                bit_idx_reg <= '0;
            end
            if (bit_tick_in && state_reg == mid_pkg::MID_ST_PARITY) begin
                parity_reg <= rx_bit_in;
            end else if (state_reg == mid_pkg::MID_ST_IDLE) begin
                parity_reg <= 1'b0;
            end
        end
    end

    // Character out: one-cycle valid, record held until the next character.
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            valid_reg <= 1'b0;
            char_reg <= '0;
        end else begin
            valid_reg <= stop_tick && is_async;
            if (stop_tick && is_async) begin
                char_reg <= '{data: shift_reg, parity: parity_reg, framing_err: !rx_bit_in};
            end
        end
    end

    assign rxd_out = rxd_reg;
    assign msg_gap_out = gap_reg;
    assign char_valid_out = valid_reg;
    assign char_out = char_reg;
    assign mode_out = mode_reg;
    assign mode_ready_out = captured_reg;

    // ------------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------------
    logic [mid_pkg::MID_CNT_W-1:0] idle_run_reg;
    logic [mid_pkg::MID_CNT_W-1:0] frame_ticks_reg;

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            idle_run_reg <= '0;
            frame_ticks_reg <= '0;
        end else begin
            if (bit_tick_in) begin
                idle_run_reg <= (rx_bit_in != idle_level) ? '0 :
                                (idle_run_reg == mid_pkg::MID_CNT_MAX) ? idle_run_reg : idle_run_reg + 1'b1;
            end
            if (state_reg == mid_pkg::MID_ST_IDLE) begin
                frame_ticks_reg <= '0;
            end else if (bit_tick_in) begin
                frame_ticks_reg <= frame_ticks_reg + 1'b1;
            end
        end
    end

    default clocking mid_cb @(posedge mclk_in); endclocking
    default disable iff (sys_rst_in);

    mode_capture_a: assert property ($rose(captured_reg) |-> mode_reg == $past(sw_mode))
        else $error("mode not taken from switches at power-up");
    mode_hold_a: assert property (captured_reg |=> $stable(mode_reg))
        else $error("mode changed after power-up");
    frame_11bit_a: assert property (char_valid_out && mode_reg == mid_pkg::MID_ASYNC11
                                    |-> frame_ticks_reg == mid_pkg::MID_FRAME11_TICKS)
        else $error("11-bit character framed with wrong bit count");
    frame_10bit_a: assert property (char_valid_out && mode_reg == mid_pkg::MID_ASYNC10
                                    |-> frame_ticks_reg == mid_pkg::MID_FRAME10_TICKS)
        else $error("10-bit character framed with wrong bit count");
    no_parity_a: assert property (state_reg == mid_pkg::MID_ST_PARITY |-> is_async11)
        else $error("parity bit taken outside 11-bit mode");
    transparent_a: assert property (captured_reg && !is_async |-> !char_valid_out && !msg_gap_out ##1 !msg_gap_out
                                    or mode_reg[2])
        else $error("framing or gap reported in transparent mode");
    idle_zero_a: assert property (mode_reg == mid_pkg::MID_OFF_IDLE0 && !carrier_in |=> rxd_out == 1'b0)
        else $error("terminal data not 0 without carrier");
    idle_one_a: assert property (mode_reg == mid_pkg::MID_OFF_IDLE1 && !carrier_in |=> rxd_out == 1'b1)
        else $error("terminal data not 1 without carrier");
    short_gap0_a: assert property (is_mid_on && mode_reg == mid_pkg::MID_SHORT_IDLE0
                                   && idle_run_reg >= mid_pkg::MID_SHORT_GAP_BITS |-> ##[1:2] msg_gap_out)
        else $error("short idle-0 interval missed");
    short_gap1_a: assert property (is_mid_on && mode_reg == mid_pkg::MID_SHORT_IDLE1
                                   && idle_run_reg >= mid_pkg::MID_SHORT_GAP_BITS |-> ##[1:2] msg_gap_out)
        else $error("short idle-1 interval missed");
    long_gap0_a: assert property (is_mid_on && mode_reg == mid_pkg::MID_LONG_IDLE0
                                  && idle_run_reg >= mid_pkg::MID_LONG_GAP_BITS |-> ##[1:2] msg_gap_out)
        else $error("long idle-0 interval missed");
    long_gap1_a: assert property (is_mid_on && mode_reg == mid_pkg::MID_LONG_IDLE1
                                  && idle_run_reg >= mid_pkg::MID_LONG_GAP_BITS |-> ##[1:2] msg_gap_out)
        else $error("long idle-1 interval missed");
    gap_early_a: assert property ($past(is_mid_on, 2) && msg_gap_out |-> $past(idle_run_reg) >= gap_threshold)
        else $error("interval flagged before idle run complete");
    default_mode_a: assert property ($rose(captured_reg) && $past(mode_sw_in) == 3'h0
                                     |-> mode_reg == mid_pkg::MID_ASYNC11)
        else $error("default code did not select 11-bit mode");

    char11_c: cover property (char_valid_out && is_async11 && !char_out.framing_err);
    char10_c: cover property (char_valid_out && is_async10);
    gap_long_c: cover property (msg_gap_out && mode_reg[1]);
    carrier_off_c: cover property (is_mid_off && $fell(carrier_in));

endmodule // mid_detector

// file: verilog/mid_gap_counter.sv
// Idle-run counter: counts bit times spent at the idle level and flags a
// message interval once the run reaches the threshold.
// Assumes bit_tick_in is a one-cycle strobe once per bit time.
module mid_gap_counter (
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire logic enable_in,
    input wire logic bit_tick_in,
    input wire logic rx_bit_in,
    input wire logic idle_level_in,
    input wire logic [mid_pkg::MID_CNT_W-1:0] threshold_in,
    output logic gap_out
);

    logic [mid_pkg::MID_CNT_W-1:0] cnt_reg;
    logic [mid_pkg::MID_CNT_W-1:0] cnt_next;
    logic gap_reg;
    wire logic at_idle = (rx_bit_in == idle_level_in);
    wire logic saturated = (cnt_reg == mid_pkg::MID_CNT_MAX);

    // Restart on any non-idle bit, saturate so a long idle stays flagged.
    assign cnt_next = !enable_in ? '0 :
                      !bit_tick_in ? cnt_reg :
                      !at_idle ? '0 :
                      saturated ? cnt_reg : cnt_reg + 1'b1;

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            cnt_reg <= '0;
            gap_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            gap_reg <= enable_in && (cnt_next >= threshold_in);
        end
    end

    assign gap_out = gap_reg;

endmodule // mid_gap_counter
